// File: src/pfcl_pkg.sv
// Constants and types for the parallel flash configuration loader.
// Assumes a 20 MHz system clock; all times are converted to cycles here.
package pfcl_pkg;
  // System clock rate in Hz
  localparam int unsigned SYS_CLK_HZ = 20000000;
  // Configuration clock target rate in Hz, never exceeded
  localparam int unsigned CFG_CLK_HZ = 40000000;
  // Divider half period, at least one system cycle
  localparam int unsigned CFG_HALF_RAW = SYS_CLK_HZ / (2 * CFG_CLK_HZ);
  localparam int unsigned CFG_HALF_CYC = (CFG_HALF_RAW < 1) ? 1 : CFG_HALF_RAW;
  // Power-on reset windows in microseconds (exclusive bounds)
  localparam int unsigned POR_FAST_MIN_US = 3000;
  localparam int unsigned POR_FAST_MAX_US = 9000;
  localparam int unsigned POR_STD_MIN_US = 50000;
  localparam int unsigned POR_STD_MAX_US = 200000;
  // Chosen hold: just above the least time, well below the longest
  localparam int unsigned POR_FAST_CYC =
    (POR_FAST_MIN_US * (SYS_CLK_HZ / 1000000)) + 1;
  localparam int unsigned POR_STD_CYC =
    (POR_STD_MIN_US * (SYS_CLK_HZ / 1000000)) + 1;
  // Initialization cycles after configuration completes
  localparam int unsigned INIT_CYC = 3185;
  // Image length in 16-bit words, default
  localparam int unsigned IMAGE_WORDS = 1024;
  // Cycles from address strobe to first valid burst word
  localparam int unsigned FIRST_LAT_CYC = 4;
  // Widths
  localparam int unsigned ADDR_W = 24;
  localparam int unsigned DATA_W = 16;
  // Start address of the image and the filler mark that flags a frame error
  localparam logic [23:0] IMAGE_BASE = 24'h000000;
  localparam logic [15:0] FRAME_MARK = 16'hffff;
  // Scheme select encodings
  localparam logic [3:0] SCHEME_FAST_A = 4'h5;
  localparam logic [3:0] SCHEME_FAST_B = 4'h6;
  // Stage machine, one-hot
  typedef enum logic [5:0] {
    PFCL_POR = 6'h01,
    PFCL_RESET = 6'h02,
    PFCL_ADDR = 6'h04,
    PFCL_BURST = 6'h08,
    PFCL_INIT = 6'h10,
    PFCL_USER = 6'h20
  } pfcl_stage_e;
endpackage

// File: src/pfcl_sync.sv
// Two-flop synchroniser for a single level from outside the clock domain.
// Assumes the input is a plain level; first flop feeds only the second.
`timescale 1ns/100ps
`default_nettype none
module pfcl_sync (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic async_in,
  output logic sync_out
);
  // First stage, read only by the second
  logic meta_q;
  // Two flops in series
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      meta_q <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule // pfcl_sync
`default_nettype wire

// File: src/pfcl_timer.sv
// Loadable down-counter used for the power-on and initialization waits.
// Assumes a load value is presented for one cycle with load_in high.
`timescale 1ns/100ps
`default_nettype none
module pfcl_timer (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic load_in,
  input wire logic [22:0] value_in,
  output logic done_out
);
  // Remaining cycles
  logic [22:0] count_q;
  // Count down to zero and stop there
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      count_q <= 23'h000000;
    end else if (load_in) begin
      count_q <= value_in;
    end else if (count_q != 23'h000000) begin
      count_q <= count_q - 23'h000001;
    end
  end
  // Done while idle at zero; load_in is left out on purpose, since the
  // loader's load logic reads done and a gate here would close a loop
  assign done_out = (count_q == 23'h000000);
endmodule // pfcl_timer
`default_nettype wire

// File: src/pfcl_loader.sv
// Active parallel configuration loader: masters a 16-bit burst NOR flash.
// Assumes 20 MHz sys_clk_in; request, status, complete and data pins pass a two-flop synchroniser.
// Overview of operation
// - Drive clock, reset, enable, strobes; low-active
// - 24-bit word address onto flash A1 upward
// - 16-bit data bus, flash drives reads only
// - Ignore wait; use fixed burst timing
// - Config clock derived from internal oscillator
// - Config reads never exceed 40 MHz
// - Output enable low opens flash drivers
// - Address valid low latches address
// - Write enable low writes flash words
// - Hard reset of flash, active low
// - Fast scheme: reset hold 3 to 9 ms
// - Standard scheme: hold 50 to 200 ms
// - During reset: status, complete low; tri-state
// - User I/O tri-stated, pull-ups until done
// - Stages: reset, configuration, initialization
// - Stay reset while request or status low
// - Release status, configure once line high
// - Count 3185 init cycles before user mode
// - Frame error: status low, complete low
`timescale 1ns/100ps
`default_nettype none
module pfcl_loader
  import pfcl_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  input wire logic [3:0] scheme_select_in,
  input wire logic reconfig_request_n_in,
  input wire logic config_status_n_in,
  input wire logic config_complete_in,
  input wire logic flash_data_not_ready_in,
  input wire logic [15:0] flash_data_in,
  output logic config_clock_out,
  output logic flash_hard_reset_n_out,
  output logic flash_chip_enable_n_out,
  output logic flash_output_enable_n_out,
  output logic addr_valid_n_out,
  output logic flash_write_enable_n_out,
  output logic [23:0] config_address_bus_out,
  output logic [15:0] flash_data_out,
  output logic flash_data_oe_out,
  output logic config_status_n_oe_out,
  output logic config_complete_oe_out,
  output logic user_io_enable_out,
  output logic weak_pullup_enable_out,
  output logic [15:0] image_word_out,
  output logic image_word_valid_out,
  output logic user_mode_out
);
  // Synchronised pin levels
  logic reconfig_s;
  logic status_s;
  logic complete_s;
  logic [15:0] data_s;
  // Stage register
  pfcl_stage_e stage_q;
  pfcl_stage_e stage_d;
  // Timer control
  logic tmr_load;
  logic [22:0] tmr_value;
  logic tmr_done;
  // Burst bookkeeping
  logic [23:0] addr_q;
  logic [15:0] words_q;
  logic [2:0] lat_q;
  logic clk_phase_q;
  logic [15:0] frame_q;
  logic frame_err;
  // High on the cycle a fresh flash word sits on data_s
  logic take_q;
  // Latched frame error, holds status low until a reconfig request
  logic err_q;
  // Scheme decoded once
  logic fast_scheme;

  // Level synchronisers for control pins
  pfcl_sync u_sync_cfg (
    .clk_in(sys_clk_in),
    .reset_n_in(reset_n_in),
    .async_in(reconfig_request_n_in),
    .sync_out(reconfig_s)
  );
  pfcl_sync u_sync_sts (
    .clk_in(sys_clk_in),
    .reset_n_in(reset_n_in),
    .async_in(config_status_n_in),
    .sync_out(status_s)
  );
  pfcl_sync u_sync_done (
    .clk_in(sys_clk_in),
    .reset_n_in(reset_n_in),
    .async_in(config_complete_in),
    .sync_out(complete_s)
  );
  // Data bus synchronisers, one per bit
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_dsync
      pfcl_sync u_sync_d (
        .clk_in(sys_clk_in),
        .reset_n_in(reset_n_in),
        .async_in(flash_data_in[gi]),
        .sync_out(data_s[gi])
      );
    end
  endgenerate

  // Shared down-counter for power-on and init waits
  pfcl_timer u_timer (
    .clk_in(sys_clk_in),
    .reset_n_in(reset_n_in),
    .load_in(tmr_load),
    .value_in(tmr_value),
    .done_out(tmr_done)
  );

  // Fast scheme when either fast encoding is strapped
  assign fast_scheme = (scheme_select_in == SCHEME_FAST_A) ||
                       (scheme_select_in == SCHEME_FAST_B);
  // A word equal to the filler mark in the frame header is an error
  assign frame_err = (stage_q == PFCL_BURST) && (lat_q == 3'h0) &&
                     take_q && (words_q == 16'h0000) &&
                     (data_s == FRAME_MARK);

  // Timer load values per stage entry
  always_comb begin
    tmr_load = 1'b0;
    tmr_value = 23'h000000;
    if (stage_q == PFCL_POR && stage_d == PFCL_POR && clk_phase_q &&
        frame_q == 16'h0000) begin
      tmr_load = 1'b1;
      tmr_value = fast_scheme ? 23'(POR_FAST_CYC) : 23'(POR_STD_CYC);
    end else if (stage_q == PFCL_BURST && stage_d == PFCL_INIT) begin
      tmr_load = 1'b1;
      tmr_value = 23'(INIT_CYC);
    end else if (stage_q == PFCL_INIT && !complete_s) begin
      // Count only once the complete line reads high
      tmr_load = 1'b1;
      tmr_value = 23'(INIT_CYC);
    end
  end

  // Stage sequencing
  always_comb begin
    stage_d = stage_q;
    case (stage_q)
      PFCL_POR: begin
        // Leave once the hold timer ran out after being armed
        if (tmr_done && frame_q == 16'h0001) begin
          stage_d = PFCL_RESET;
        end
      end
      PFCL_RESET: begin
        // proceed once status high
        // Latched frame error keeps us here until a request clears it
        if (reconfig_s && status_s && !err_q) begin
          stage_d = PFCL_ADDR;
        end
      end
      PFCL_ADDR: begin
        // One strobe cycle then burst
        stage_d = PFCL_BURST;
      end
      PFCL_BURST: begin
        if (!reconfig_s || frame_err) begin
          stage_d = PFCL_RESET;
        end else if (take_q && lat_q == 3'h0 &&
                     words_q == 16'(IMAGE_WORDS - 1)) begin
          stage_d = PFCL_INIT;
        end
      end
      PFCL_INIT: begin
        if (!reconfig_s) begin
          stage_d = PFCL_RESET;
        end else if (tmr_done && complete_s) begin
          stage_d = PFCL_USER;
        end
      end
      PFCL_USER: begin
        // Reconfiguration request restarts from reset
        if (!reconfig_s) begin
          stage_d = PFCL_RESET;
        end
      end
      default: stage_d = PFCL_POR;
    endcase
  end

  // Stage register
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      stage_q <= PFCL_POR;
    end else begin
      stage_q <= stage_d;
    end
  end

  // Power-on arm flag kept in frame_q bit 0 while in POR
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      frame_q <= 16'h0000;
      clk_phase_q <= 1'b0;
    end else begin
      // One cycle settle before arming the hold timer
      clk_phase_q <= 1'b1;
      if (tmr_load && stage_q == PFCL_POR) begin
        frame_q <= 16'h0001;
      end
    end
  end

  // Frame error latch; a set wins over a clear in the same cycle
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      err_q <= 1'b0;
    end else if (frame_err) begin
      err_q <= 1'b1;
    end else if (!reconfig_s) begin
      err_q <= 1'b0;
    end
  end

  // Burst address, latency and word counters
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      addr_q <= IMAGE_BASE;
      words_q <= 16'h0000;
      lat_q <= 3'h0;
      take_q <= 1'b0;
    end else if (stage_q == PFCL_ADDR) begin
      addr_q <= IMAGE_BASE;
      words_q <= 16'h0000;
      lat_q <= 3'(FIRST_LAT_CYC);
      take_q <= 1'b1;
    end else if (stage_q == PFCL_BURST) begin
      if (lat_q != 3'h0) begin
        lat_q <= lat_q - 3'h1;
      end else begin
        // One word per config clock: each stands two system cycles
        take_q <= ~take_q;
        if (take_q) begin
          words_q <= words_q + 16'h0001;
          addr_q <= addr_q + 24'h000001;
        end
      end
    end
  end

  // Flash control pins, all registered
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      config_clock_out <= 1'b0;
      flash_hard_reset_n_out <= 1'b0;
      flash_chip_enable_n_out <= 1'b1;
      flash_output_enable_n_out <= 1'b1;
      addr_valid_n_out <= 1'b1;
      flash_write_enable_n_out <= 1'b1;
      config_address_bus_out <= 24'h000000;
      flash_data_out <= 16'h0000;
      flash_data_oe_out <= 1'b0;
    end else begin
      config_clock_out <= (stage_d == PFCL_ADDR || stage_d == PFCL_BURST) ?
                          ~config_clock_out : 1'b0;
      flash_hard_reset_n_out <= (stage_d != PFCL_POR);
      flash_chip_enable_n_out <= !(stage_d == PFCL_ADDR ||
                                   stage_d == PFCL_BURST);
      flash_output_enable_n_out <= (stage_d != PFCL_BURST);
      addr_valid_n_out <= (stage_d != PFCL_ADDR);
      flash_write_enable_n_out <= 1'b1;
      config_address_bus_out <= (stage_d == PFCL_ADDR) ? IMAGE_BASE : addr_q;
      flash_data_out <= 16'h0000;
      flash_data_oe_out <= 1'b0;
    end
  end

  // Status, complete and user I/O pins
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      config_status_n_oe_out <= 1'b1;
      config_complete_oe_out <= 1'b1;
      user_io_enable_out <= 1'b0;
      weak_pullup_enable_out <= 1'b0;
      user_mode_out <= 1'b0;
    end else begin
      config_status_n_oe_out <= (stage_d == PFCL_POR) ||
                                frame_err || err_q;
      // Complete held low until burst finished
      config_complete_oe_out <= !(stage_d == PFCL_INIT ||
                                  stage_d == PFCL_USER);
      user_io_enable_out <= (stage_d == PFCL_USER);
      weak_pullup_enable_out <= (stage_d != PFCL_POR) &&
                                (stage_d != PFCL_USER);
      user_mode_out <= (stage_d == PFCL_USER);
    end
  end

  // Image word stream to configuration memory
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      image_word_out <= 16'h0000;
      image_word_valid_out <= 1'b0;
    end else begin
      image_word_out <= data_s;
      image_word_valid_out <= (stage_q == PFCL_BURST) && (lat_q == 3'h0) &&
                              take_q && !frame_err && reconfig_s;
    end
  end
endmodule // pfcl_loader
`default_nettype wire

// File: tb/pfcl_flash_model.sv
// Burst NOR flash stand-in for the configuration loader.
// Assumes it runs on the loader's system clock and sees its flash pins.
`timescale 1ns/100ps
`default_nettype none
module pfcl_flash_model (
  input wire logic sys_clk_in,
  input wire logic hard_reset_n_in,
  input wire logic chip_enable_n_in,
  input wire logic output_enable_n_in,
  input wire logic addr_valid_n_in,
  input wire logic config_clock_in,
  input wire logic [23:0] address_in,
  input wire logic frame_err_in,
  output logic [15:0] data_out,
  output logic not_ready_out
);
  logic [23:0] ptr_q; // Next burst word address
  logic [15:0] word_q; // Word on the bus
  logic first_q; // First word of a burst pending
  logic clk_prev_q; // Config clock one cycle ago
  logic wait_q; // Wait pattern while released
  // Hard reset drops back to idle reads
  // Latch, then launch on clock rise
  always_ff @(posedge sys_clk_in or negedge hard_reset_n_in) begin
    if (!hard_reset_n_in) begin
      ptr_q <= 24'h000000;
      word_q <= 16'h0000;
      first_q <= 1'b0;
      clk_prev_q <= 1'b0;
      wait_q <= 1'b0;
    end else begin
      clk_prev_q <= config_clock_in;
      wait_q <= ~wait_q;
      if (!addr_valid_n_in && !chip_enable_n_in) begin
        // Board ties extra lines; 24 decoded
        ptr_q <= address_in;
        first_q <= 1'b1;
      end else if (config_clock_in && !clk_prev_q &&
                   !output_enable_n_in) begin
        // Corrupt first word only when the bench asks for it
        word_q <= (frame_err_in && first_q) ? 16'hffff :
                  {8'ha5, ptr_q[7:0]};
        ptr_q <= ptr_q + 24'h000001;
        first_q <= 1'b0;
      end
    end
  end
  // Released bus shows no stale word
  assign data_out = (!output_enable_n_in && !chip_enable_n_in) ?
                    word_q : ~word_q;
  assign not_ready_out = wait_q;
endmodule // pfcl_flash_model
`default_nettype wire

// File: tb/pfcl_loader_asserts.sv
// Timing and pin checks on the configuration loader's ports.
// Assumes binding onto pfcl_loader with the 20 MHz system clock.
`timescale 1ns/100ps
`default_nettype none
module pfcl_loader_asserts
  import pfcl_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  input wire logic [3:0] scheme_select_in,
  input wire logic reconfig_request_n_in,
  input wire logic config_complete_in,
  input wire logic config_clock_out,
  input wire logic flash_hard_reset_n_out,
  input wire logic flash_chip_enable_n_out,
  input wire logic flash_output_enable_n_out,
  input wire logic addr_valid_n_out,
  input wire logic flash_write_enable_n_out,
  input wire logic flash_data_oe_out,
  input wire logic config_status_n_oe_out,
  input wire logic config_complete_oe_out,
  input wire logic user_io_enable_out,
  input wire logic weak_pullup_enable_out,
  input wire logic image_word_valid_out,
  input wire logic user_mode_out
);
  // Hold windows in system cycles
  localparam int FAST_LO = 60000;
  localparam int FAST_HI = 180000;
  localparam int STD_LO = 1000000;
  localparam int STD_HI = 4000000;
  localparam int INIT_LO = 3185;
  localparam int INIT_HI = 3200;
  logic [22:0] por_cnt_q; // Cycles of power-on hold
  logic [12:0] init_cnt_q; // Cycles with complete line high
  logic fast; // Short hold strapped
  assign fast = (scheme_select_in == SCHEME_FAST_A) ||
    (scheme_select_in == SCHEME_FAST_B);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);
  // Saturates so a long hold never wraps
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      por_cnt_q <= 23'h000000;
    end else if (!flash_hard_reset_n_out && (por_cnt_q != 23'h7fffff)) begin
      por_cnt_q <= por_cnt_q + 23'h000001;
    end
  end
  // Restarts whenever the complete line is low
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      init_cnt_q <= 13'h0000;
    end else if (!config_complete_in || config_complete_oe_out) begin
      init_cnt_q <= 13'h0000;
    end else if (init_cnt_q != 13'h1fff) begin
      init_cnt_q <= init_cnt_q + 13'h0001;
    end
  end
  sequence s_strobe;
    !flash_chip_enable_n_out ##1 (addr_valid_n_out && !flash_chip_enable_n_out);
  endsequence
  sequence s_open;
    !flash_output_enable_n_out [*4];
  endsequence
  chk_no_write: assert property (flash_write_enable_n_out)
    else $error("flash write strobe asserted");
  chk_data_release: assert property (
    !(flash_data_oe_out && !flash_output_enable_n_out))
    else $error("data bus contention");
  chk_oe_needs_ce: assert property (
    !flash_output_enable_n_out |-> !flash_chip_enable_n_out)
    else $error("output enable without chip enable");
  chk_strobe_pulse: assert property (
    $fell(addr_valid_n_out) |-> s_strobe)
    else $error("address strobe not a single cycle");
  chk_burst_follows: assert property (
    $fell(addr_valid_n_out) |-> ##1 s_open)
    else $error("burst read not opened after strobe");
  chk_clk_cap: assert property (
    config_clock_out |=> !config_clock_out)
    else $error("config clock too fast");
  chk_por_pins: assert property (
    !flash_hard_reset_n_out |-> config_status_n_oe_out &&
      config_complete_oe_out && !user_io_enable_out)
    else $error("pins wrong during power-on hold");
  chk_fast_hold: assert property (
    $rose(flash_hard_reset_n_out) && fast |->
      por_cnt_q > FAST_LO && por_cnt_q < FAST_HI)
    else $error("short power-on hold out of window");
  chk_std_hold: assert property (
    $rose(flash_hard_reset_n_out) && !fast |->
      por_cnt_q > STD_LO && por_cnt_q < STD_HI)
    else $error("long power-on hold out of window");
  chk_stay_reset: assert property (
    (!reconfig_request_n_in) [*5] |->
      addr_valid_n_out && !image_word_valid_out)
    else $error("activity while reconfig held low");
  chk_pullup_pins: assert property (
    $past(flash_hard_reset_n_out) && !user_mode_out |->
      weak_pullup_enable_out && !user_io_enable_out)
    else $error("user pins wrong before user mode");
  chk_init_wait: assert property (
    $rose(user_mode_out) |->
      init_cnt_q >= INIT_LO && init_cnt_q <= INIT_HI)
    else $error("initialization count wrong");
  chk_error_done: assert property (
    config_status_n_oe_out && flash_hard_reset_n_out |->
      config_complete_oe_out)
    else $error("complete released during error");
  chk_error_hold: assert property (
    config_status_n_oe_out && flash_hard_reset_n_out &&
      reconfig_request_n_in |=> config_status_n_oe_out)
    else $error("error status released without a request");
endmodule // pfcl_loader_asserts
bind pfcl_loader pfcl_loader_asserts i_pfcl_loader_asserts (
  .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
  .scheme_select_in(scheme_select_in),
  .reconfig_request_n_in(reconfig_request_n_in),
  .config_complete_in(config_complete_in),
  .config_clock_out(config_clock_out),
  .flash_hard_reset_n_out(flash_hard_reset_n_out),
  .flash_chip_enable_n_out(flash_chip_enable_n_out),
  .flash_output_enable_n_out(flash_output_enable_n_out),
  .addr_valid_n_out(addr_valid_n_out),
  .flash_write_enable_n_out(flash_write_enable_n_out),
  .flash_data_oe_out(flash_data_oe_out),
  .config_status_n_oe_out(config_status_n_oe_out),
  .config_complete_oe_out(config_complete_oe_out),
  .user_io_enable_out(user_io_enable_out),
  .weak_pullup_enable_out(weak_pullup_enable_out),
  .image_word_valid_out(image_word_valid_out),
  .user_mode_out(user_mode_out));
`default_nettype wire

// File: tb/pfcl_loader_tb.sv
// Bench for the loader: power-on, full load, reconfig, frame error.
// Assumes the flash model and the bound checker are compiled first.
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_mismatch++; \
  $display("Error %0t: got %h want %h", $time, (a), (b)); end end
module pfcl_loader_tb
  import pfcl_pkg::*;
;
  logic sys_clk_in = 1'b0, reset_n_in, reconfig_n, frame_err;
  logic [3:0] scheme;
  wire logic cclk, hrst_n, ce_n, oe_n, avd_n, we_n, d_oe, st_oe, cd_oe;
  wire logic uio, pull, wvalid, umode, fwait;
  wire logic [23:0] addr;
  wire logic [15:0] d_out, wdata, mdata;
  int n_mismatch = 0, n_compared = 0, n_words = 0, por_cyc;
  logic [15:0] first_word; // First image word seen
  // Bus resolution: loader wins only while it drives
  wire logic [15:0] d_in = d_oe ? d_out : mdata;
  initial forever #25 sys_clk_in = ~sys_clk_in;
  pfcl_loader i_pfcl_loader (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
    .scheme_select_in(scheme), .reconfig_request_n_in(reconfig_n),
    .config_status_n_in(!st_oe), .config_complete_in(!cd_oe),
    .flash_data_not_ready_in(fwait), .flash_data_in(d_in),
    .config_clock_out(cclk), .flash_hard_reset_n_out(hrst_n),
    .flash_chip_enable_n_out(ce_n), .flash_output_enable_n_out(oe_n),
    .addr_valid_n_out(avd_n), .flash_write_enable_n_out(we_n),
    .config_address_bus_out(addr), .flash_data_out(d_out),
    .flash_data_oe_out(d_oe), .config_status_n_oe_out(st_oe),
    .config_complete_oe_out(cd_oe), .user_io_enable_out(uio),
    .weak_pullup_enable_out(pull), .image_word_out(wdata),
    .image_word_valid_out(wvalid), .user_mode_out(umode));
  pfcl_flash_model i_pfcl_flash_model (.sys_clk_in(sys_clk_in),
    .hard_reset_n_in(hrst_n), .chip_enable_n_in(ce_n),
    .output_enable_n_in(oe_n), .addr_valid_n_in(avd_n),
    .config_clock_in(cclk), .address_in(addr), .frame_err_in(frame_err),
    .data_out(mdata), .not_ready_out(fwait));
  // Word counter and sequence check; first word kept for the address check
  always @(negedge sys_clk_in) begin
    if (wvalid === 1'b1) begin
      if (n_words == 0) first_word = wdata;
      `CHK(wdata, {8'ha5, IMAGE_BASE[7:0] + 8'(n_words)})
      n_words++;
    end
  end
  task print_verdict;
    $display("Compared %0d, mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  function automatic logic cond(input int sel);
    case (sel)
      0: return hrst_n === 1'b1;
      1: return umode === 1'b1;
      2: return st_oe === 1'b1;
      default: return avd_n === 1'b0;
    endcase
  endfunction
  // Bounded wait; running out ends the run
  task wait_sig(input int sel, input int lim);
    int i;
    for (i = 0; i < lim; i++) begin
      @(negedge sys_clk_in);
      if (cond(sel)) return;
    end
    n_mismatch++;
    $display("Error %0t: wait timed out", $time);
    print_verdict();
  endtask
  // Reconfig pulse well past the synchroniser depth
  task pulse_reconfig;
    reconfig_n = 1'b0;
    n_words = 0;
    repeat (20) @(negedge sys_clk_in);
    `CHK(umode, 1'b0)
    `CHK(cd_oe, 1'b1)
    reconfig_n = 1'b1;
  endtask
  initial begin
    reset_n_in = 1'b0;
    scheme = SCHEME_FAST_A;
    reconfig_n = 1'b1;
    frame_err = 1'b0;
    repeat (12) @(negedge sys_clk_in);
    reset_n_in = 1'b1;
    @(negedge sys_clk_in);
    `CHK(hrst_n, 1'b0)
    `CHK(st_oe, 1'b1)
    `CHK(uio, 1'b0)
    por_cyc = 1;
    while (hrst_n !== 1'b1 && por_cyc < 70000) begin
      @(negedge sys_clk_in);
      por_cyc++;
    end
    `CHK(por_cyc > 59999 && por_cyc < 70000, 1'b1)
    `CHK(pull, 1'b1)
    $display("Test power-on hold done");
    wait_sig(1, 10000);
    `CHK(n_words, IMAGE_WORDS)
    `CHK(first_word, {8'ha5, IMAGE_BASE[7:0]})
    `CHK(uio, 1'b1)
    `CHK(pull, 1'b0)
    $display("Test first load done");
    pulse_reconfig();
    wait_sig(1, 10000);
    `CHK(n_words, IMAGE_WORDS)
    $display("Test reconfig done");
    frame_err = 1'b1;
    pulse_reconfig();
    wait_sig(3, 100);
    wait_sig(2, 1000);
    `CHK(cd_oe, 1'b1)
    `CHK(umode, 1'b0)
    repeat (40) @(negedge sys_clk_in);
    `CHK(st_oe, 1'b1)
    `CHK(avd_n, 1'b1)
    $display("Test frame error done");
    frame_err = 1'b0;
    pulse_reconfig();
    wait_sig(1, 10000);
    `CHK(n_words, IMAGE_WORDS)
    $display("Test error recovery done");
    print_verdict();
  end
endmodule // pfcl_loader_tb
`default_nettype wire
